// ### hw/papc_pkg.sv
// Package for the page access permission checker.
// Assumes a single core clock; shared by all design files.
package papc_pkg;

  // ==========================================================
  // Entry field positions
  localparam int unsigned ENTRY_WIDTH = 32;
  localparam int unsigned RW_BIT      = 1;
  localparam int unsigned US_BIT      = 2;

  // ==========================================================
  // Privilege encodings
  localparam logic [1:0] CPL_USER      = 2'h3;
  localparam logic [1:0] CPL_KERNEL    = 2'h0;

  // ==========================================================
  // Register map (Wishbone, byte addresses)
  localparam logic [3:0] ADDR_CTRL     = 4'h0;
  localparam logic [3:0] ADDR_STATUS   = 4'h4;
  localparam logic [3:0] ADDR_COUNT    = 4'h8;
  localparam int unsigned CTRL_WP_BIT  = 0;
  localparam logic        WP_RESET     = 1'b0;
  localparam int unsigned CNT_WIDTH    = 16;

  // ==========================================================
  // Carriers
  typedef struct packed {
    logic [31:0] lin_addr;
    logic [31:0] phys_addr;
    logic [31:0] dir_entry;
    logic [31:0] tbl_entry;
    logic [1:0]  current_privilege_level;
    logic        write;
    logic        desc_access;
    logic        inner_stack;
    logic        seg_fault;
  } papc_req_t;

  typedef struct packed {
    logic        user;
    logic        rw;
  } papc_attr_t;

  typedef struct packed {
    logic [31:0] phys_addr;
    logic        permit;
    logic        page_fault;
    logic        suppress;
  } papc_resp_t;

endpackage

// ### hw/papc_attr.sv
// Combines directory and table entry attributes into one effective pair.
// Assumes pure combinational use inside the checker.
`timescale 1ns/1ns
`default_nettype none
module papc_attr
  import papc_pkg::*;
(
  input  wire logic [31:0] dir_entry_i,
  input  wire logic [31:0] tbl_entry_i,
  output var  papc_attr_t  attr_o
);
  // ==========================================================
  // Combination
  // User only when both levels are user; writable only when both are
  always_comb begin
    attr_o.user = dir_entry_i[US_BIT] & tbl_entry_i[US_BIT];
    attr_o.rw   = dir_entry_i[RW_BIT] & tbl_entry_i[RW_BIT];
  end
endmodule
`default_nettype wire

// ### hw/papc_wb.sv
// Wishbone classic slave holding control and status registers.
// Assumes a master that holds the request until ack.
`timescale 1ns/1ns
`default_nettype none
module papc_wb
  import papc_pkg::*;
(
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  input  wire logic                 cyc_i,
  input  wire logic                 stb_i,
  input  wire logic                 we_i,
  input  wire logic [3:0]           adr_i,
  input  wire logic [3:0]           sel_i,
  input  wire logic [31:0]          dat_i,
  output logic      [31:0]          dat_o,
  output logic                      ack_o,
  input  wire logic                 last_fault_i,
  input  wire logic [CNT_WIDTH-1:0] fault_cnt_i,
  output logic                      wp_o
);
  logic req;
  assign req = cyc_i & stb_i & ~ack_o;

  // ==========================================================
  // One-wait ack
  always_ff @(posedge clk_i) begin
    if (rst_i) ack_o <= 1'b0;
    else       ack_o <= req;
  end

  // Write-protect bit; reset clears it
  always_ff @(posedge clk_i) begin
    if (rst_i) wp_o <= WP_RESET;
    else if (req && we_i && adr_i == ADDR_CTRL && sel_i[0])
      wp_o <= dat_i[CTRL_WP_BIT];
  end

  // Read data; unmapped reads return zero
  always_ff @(posedge clk_i) begin
    if (rst_i) dat_o <= 32'h0;
    else if (req && !we_i) begin
      unique case (adr_i)
        ADDR_CTRL:   dat_o <= {31'h0, wp_o};
        ADDR_STATUS: dat_o <= {31'h0, last_fault_i};
        ADDR_COUNT:  dat_o <= {16'h0, fault_cnt_i};
        default:     dat_o <= 32'h0;
      endcase
    end
  end
endmodule
`default_nettype wire

// ### hw/papc_top.sv
// Page access permission checker, top level.
// Assumes requests come from translation logic on the same clock.
//
// Functional notes
// - R/W flag 0 is read-only, 1 is read/write.
// - Supervisor with write-protect clear may read and write any page.
// - Write-protect bit clears at reset.
// - User writes need a user page that is read/write.
// - User reads allowed on any user page.
// - User access to supervisor pages is blocked.
// - Any page violation without a segment fault raises a page fault.
// - Write-protect set blocks supervisor writes to read-only user pages.
// - Both directory and table entries are examined.
// - User only if both user; read/write only if both read/write.
// - Supervisor page is read/write unless write-protect uses both flags.
// - Descriptor table accesses are checked at level 0.
// - Inner stack accesses on privilege change are checked at level 0.
// - Segment result applies first, then page check.
// - Any failing check suppresses the access.
// - No page fault when segmentation already faulted.
// - Page attributes never grant what segmentation denies.
// - Levels 0 to 2 are supervisor, 3 is user.
// - Writable from bit 1, user flag from bit 2.
// - User flag 0 means supervisor page, 1 user page.
// - Verdict is ready before any memory cycle starts.
`timescale 1ns/1ns
`default_nettype none
module papc_top
  import papc_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        req_valid_i,
  input  wire papc_req_t   req_i,
  output var  logic        rsp_valid_o,
  output var  papc_resp_t  rsp_o,
  output var  logic        mem_start_o,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [3:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o
);
  papc_attr_t             attr;
  logic                   wp;
  logic                   eff_user_mode;
  logic                   allow;
  logic                   next_fault;
  logic                   next_suppress;
  logic                   last_fault;
  logic [CNT_WIDTH-1:0]   fault_cnt;

  // ==========================================================
  // Attribute combination of both table levels
  papc_attr u_attr (
    .dir_entry_i (req_i.dir_entry),
    .tbl_entry_i (req_i.tbl_entry),
    .attr_o      (attr)
  );

  // ==========================================================
  // Register slave
  papc_wb u_wb (
    .clk_i        (clk_i),
    .rst_i        (rst_i),
    .cyc_i        (cyc_i),
    .stb_i        (stb_i),
    .we_i         (we_i),
    .adr_i        (adr_i),
    .sel_i        (sel_i),
    .dat_i        (dat_i),
    .dat_o        (dat_o),
    .ack_o        (ack_o),
    .last_fault_i (last_fault),
    .fault_cnt_i  (fault_cnt),
    .wp_o         (wp)
  );

  // ==========================================================
  // Permission function, shared decision
  function automatic logic page_ok(input logic user_mode,
                                   input logic wr,
                                   input logic wp_on,
                                   input papc_attr_t a);
    logic ok;
    ok = 1'b0;
    if (user_mode) begin
      if (!a.user)  ok = 1'b0;
      else if (!wr) ok = 1'b1;
      else          ok = a.rw;
    end else begin
      if (!wp_on)   ok = 1'b1;
      else if (!wr) ok = 1'b1;
      else          ok = a.rw;
    end
    return ok;
  endfunction

  // ==========================================================
  // Mode select: overrides force level-0 checking
  always_comb begin
    eff_user_mode = (req_i.current_privilege_level == CPL_USER);
    if (req_i.desc_access || req_i.inner_stack)
      eff_user_mode = 1'b0;
  end

  // Segment verdict first; the page check only adds denials
  always_comb begin
    allow         = page_ok(eff_user_mode, req_i.write, wp, attr);
    next_fault    = ~req_i.seg_fault & ~allow;
    next_suppress = req_i.seg_fault | ~allow;
  end

  // ==========================================================
  // Verdict register, aligned with the translated address
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rsp_valid_o <= 1'b0;
      rsp_o       <= '0;
      mem_start_o <= 1'b0;
    end else begin
      rsp_valid_o         <= req_valid_i;
      rsp_o.phys_addr     <= req_i.phys_addr;
      rsp_o.permit        <= req_valid_i & ~next_suppress;
      rsp_o.page_fault    <= req_valid_i & next_fault;
      rsp_o.suppress      <= req_valid_i & next_suppress;
      // Memory start gated by the same verdict, never ahead of it
      mem_start_o         <= req_valid_i & ~next_suppress;
    end
  end

  // Status: sticky-free last verdict plus saturating fault count
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      last_fault <= 1'b0;
      fault_cnt  <= '0;
    end else if (req_valid_i) begin
      last_fault <= next_fault;
      if (next_fault && fault_cnt != {CNT_WIDTH{1'b1}})
        fault_cnt <= fault_cnt + 1'b1;
    end
  end
endmodule
`default_nettype wire

// ### testbench/papc_chk_checker.sv
// Concurrent checks on the permission checker top-level ports.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ns
`default_nettype none
module papc_chk
  import papc_pkg::*;
(
  input wire logic       clk_i,
  input wire logic       rst_i,
  input wire logic       req_valid_i,
  input wire papc_req_t  req_i,
  input wire logic       rsp_valid_o,
  input wire papc_resp_t rsp_o,
  input wire logic       mem_start_o,
  input wire logic       cyc_i,
  input wire logic       stb_i,
  input wire logic       ack_o
);
  // ============================================================
  // Effective mode and page privilege of the incoming request
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire logic umode = req_i.current_privilege_level == 2'h3 && !req_i.desc_access
                     && !req_i.inner_stack;
  wire logic upage = req_i.dir_entry[2] && req_i.tbl_entry[2];
  wire logic go    = req_valid_i && !req_i.seg_fault;
  // ============================================================
  // Verdict timing, ordering and content
  rsp_follow_a: assert property (req_valid_i |=> rsp_valid_o)
    else $error("no answer after request");
  rsp_only_a: assert property (!req_valid_i |=> !rsp_valid_o)
    else $error("answer without request");
  mem_gate_a: assert property (mem_start_o == (rsp_valid_o && rsp_o.permit))
    else $error("memory start not tied to permit");
  seg_first_a: assert property (req_valid_i && req_i.seg_fault |=>
    rsp_o.suppress && !rsp_o.page_fault) else $error("segment fault order");
  verdict_pair_a: assert property (rsp_valid_o |->
    rsp_o.permit != rsp_o.suppress) else $error("permit equals suppress");
  user_block_a: assert property (go && umode && !upage |=>
    rsp_o.page_fault) else $error("user reached supervisor page");
  sup_read_a: assert property (go && !umode && !req_i.write |=>
    rsp_o.permit) else $error("supervisor read refused");
  user_read_a: assert property (go && umode && upage && !req_i.write
    |=> rsp_o.permit) else $error("user read of user page refused");
  user_write_a: assert property (go && umode && upage && req_i.write
    && !(req_i.dir_entry[1] && req_i.tbl_entry[1]) |=> rsp_o.page_fault)
    else $error("user write to read-only page allowed");
  addr_pass_a: assert property (req_valid_i |=>
    rsp_o.phys_addr == $past(req_i.phys_addr)) else $error("address lost");
  wb_ack_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o)
    else $error("bus ack not one pulse");
  cover property (rsp_valid_o && rsp_o.page_fault);
  cover property (mem_start_o);
  cover property (ack_o);
endmodule
bind papc_top papc_chk u_chk (.clk_i, .rst_i, .req_valid_i, .req_i,
  .rsp_valid_o, .rsp_o, .mem_start_o, .cyc_i, .stb_i, .ack_o);
`default_nettype wire

// ### testbench/papc_pipe.sv
// Model of the translation pipeline that feeds the checker.
// Assumes the bench calls issue and samples the answer after it.
`timescale 1ns/1ns
`default_nettype none
module papc_pipe
  import papc_pkg::*;
(
  input  wire logic      clk_i,
  output var  logic      req_valid_o,
  output var  papc_req_t req_o
);
  // ============================================================
  // Idle fields start at zero, then show the inverse of the last request so a stale request never matches
  initial begin
    req_valid_o = 1'b0;
    req_o = '0;
  end
  task automatic issue(input papc_req_t r);
    @(posedge clk_i);
    req_valid_o <= 1'b1;
    req_o <= r;
    @(posedge clk_i);
    req_valid_o <= 1'b0;
    req_o <= ~r;
  endtask
endmodule
`default_nettype wire

// ### testbench/tb.sv
// Bench: sweeps every entry, mode and override combination.
// Assumes the pipeline model and the bound checker.
`timescale 1ns/1ns
`default_nettype none
module tb;
  import papc_pkg::*;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [3:0]  adr = 4'h0;
  logic [31:0] dat = 32'h0;
  logic [31:0] q;
  logic [31:0] dat_o;
  logic        req_valid, rsp_valid, mem_start, ack_o;
  papc_req_t   req;
  papc_req_t   rr;
  papc_resp_t  rsp;
  int n_errors = 0, samples_checked = 0, cycles = 0, faults = 0;
  papc_pipe u_pipe (.clk_i, .req_valid_o(req_valid), .req_o(req));
  papc_top u_dut (.clk_i, .rst_i, .req_valid_i(req_valid), .req_i(req),
    .rsp_valid_o(rsp_valid), .rsp_o(rsp), .mem_start_o(mem_start),
    .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(4'hf),
    .dat_i(dat), .dat_o, .ack_o);
  // ============================================================
  // Clock, and a cycle ceiling well above the two sweeps
  initial forever #10 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      n_errors++;
      conclude();
    end
  end
  task automatic chk(input string nm, input logic [31:0] e, g);
    samples_checked++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Bus cycle held until ack is sampled; read data left in q
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    do @(posedge clk_i); while (ack_o !== 1'b1);
    q = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  // Index bits: cpl, write, dir rw/us, tbl rw/us, descriptor, stack
  task automatic sweep(input logic wpv);
    papc_req_t r;
    logic usr, deny;
    for (int i = 0; i < 512; i++) begin
      r = '0;
      r.current_privilege_level = i[1:0];
      r.write = i[2];
      r.dir_entry[2:1] = i[4:3];
      r.tbl_entry[2:1] = i[6:5];
      r.desc_access = i[7];
      r.inner_stack = i[8];
      r.seg_fault = (i % 7) == 0;
      r.phys_addr = 32'(i * 4096);
      usr = r.current_privilege_level == CPL_USER && !r.desc_access && !r.inner_stack;
      deny = usr ? !(i[4] && i[6]) || (r.write && !(i[3] && i[5]))
                 : wpv && r.write && !(i[3] && i[5]);
      faults += int'(deny && !r.seg_fault);
      u_pipe.issue(r);
      #1;
      chk("valid", 32'h1, 32'(rsp_valid));
      chk("permit", 32'(!(deny || r.seg_fault)), 32'(rsp.permit));
      chk("fault", 32'(deny && !r.seg_fault), 32'(rsp.page_fault));
      chk("suppress", 32'(deny || r.seg_fault), 32'(rsp.suppress));
      chk("start", 32'(!(deny || r.seg_fault)), 32'(mem_start));
      chk("addr", r.phys_addr, rsp.phys_addr);
    end
  endtask
  task automatic conclude();
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, ADDR_CTRL, 32'h0);
    chk("ctrl", 32'h0, q);
    sweep(1'b0);
    wb(1'b1, ADDR_CTRL, 32'h1);
    wb(1'b0, ADDR_CTRL, 32'h0);
    chk("ctrl", 32'h1, q);
    sweep(1'b1);
    // A user access to a supervisor page must leave the status flag set
    rr = '0;
    rr.current_privilege_level = CPL_USER;
    faults++;
    u_pipe.issue(rr);
    #1;
    chk("fault", 32'h1, 32'(rsp.page_fault));
    wb(1'b0, ADDR_STATUS, 32'h0);
    chk("status", 32'h1, q);
    wb(1'b0, ADDR_COUNT, 32'h0);
    chk("count", 32'(faults), q);
    wb(1'b1, 4'hc, 32'hffff);
    wb(1'b0, 4'hc, 32'h0);
    chk("unmapped", 32'h0, q);
    // Reset in mid-run must drop write-protect and the fault count
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, ADDR_CTRL, 32'h0);
    chk("ctrl", 32'h0, q);
    wb(1'b0, ADDR_COUNT, 32'h0);
    chk("count", 32'h0, q);
    conclude();
  end
endmodule
`default_nettype wire
